// ==== logic/fsid_pkg.sv ====
// constants and decode helpers for the fault status and identity bank
package fsid_pkg;
    // register offsets seen through the serial slave engine
    localparam logic [7:0] ADDR_FUNC1 = 8'h00;
    localparam logic [7:0] ADDR_FUNC2 = 8'h01;
    localparam logic [7:0] ADDR_FAULT = 8'h02;
    localparam logic [7:0] ADDR_IDENT = 8'h03;
    // seven-bit serial bus address of the device
    localparam logic [6:0] DEV_I2C_ADDR = 7'h38;
    // fault register layout
    localparam int BIT_ALL_SHORT_EN = 7;
    localparam int BIT_TIME_SELECT = 6;
    localparam int BIT_GROUND_SHORT = 5;
    localparam int BIT_OVERTEMP = 4;
    localparam int BIT_UNDERVOLT = 3;
    localparam int BIT_OVERCURRENT = 2;
    localparam int BIT_SOURCE_SHORT = 1;
    localparam int BIT_SOURCE_OPEN = 0;
    localparam int NUM_FAULTS = 6;
    // switching rate field inside function set register 2
    localparam int RATE_SEL_MSB = 4;
    localparam int RATE_SEL_LSB = 3;
    // reset values
    localparam logic [7:0] FUNC1_RESET = 8'h86;
    localparam logic [7:0] FUNC2_RESET = 8'h28;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // timing: ground short saturation windows in milliseconds
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int GSD_SHORT_MS = 20;
    localparam int GSD_LONG_MS = 40;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    // switching rate figures in kHz
    localparam logic [11:0] RATE_SEL0_KHZ = 12'h0c8; // 200
    localparam logic [11:0] RATE_SEL1_KHZ = 12'h190; // 400
    localparam logic [11:0] RATE_SEL2_KHZ = 12'h3e8; // 1000
    localparam logic [11:0] RATE_SEL3_KHZ = 12'h898; // 2200

    // map the two-bit rate select onto its frequency in kHz
    function automatic logic [11:0] fsid_rate_khz(input logic [1:0] sel);
        logic [11:0] khz;
        khz = RATE_SEL0_KHZ;
        case (sel)
            2'h0: khz = RATE_SEL0_KHZ;
            2'h1: khz = RATE_SEL1_KHZ;
            2'h2: khz = RATE_SEL2_KHZ;
            2'h3: khz = RATE_SEL3_KHZ;
            default: khz = RATE_SEL0_KHZ;
        endcase
        return khz;
    endfunction
endpackage

// ==== logic/fsid_fault_cell.sv ====
// one sticky fault flag, set by hardware and cleared by a host read
`timescale 1ns/1ns
module fsid_fault_cell (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic faultEvent,
    input wire logic readClear,
    output logic flag
);
    // set beats clear so a fault arriving during the read is kept
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flag <= 1'b0;
        end else if (faultEvent) begin
            flag <= 1'b1;
        end else if (readClear) begin
            flag <= 1'b0;
        end
    end
endmodule

// ==== logic/fsid_sat_timer.sv ====
// measures how long the loop stays saturated and flags a ground short
`timescale 1ns/1ns
module fsid_sat_timer #(
    parameter int MS_CYCLES_P = fsid_pkg::MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic saturated,
    input wire logic longSelect,
    output logic timeout
);
    import fsid_pkg::*;
    logic [31:0] divCount;
    logic msTick;
    logic [7:0] msCount;
    logic [7:0] msLimit;

    // window length follows the select bit live
    assign msLimit = longSelect ? 8'(GSD_LONG_MS) : 8'(GSD_SHORT_MS);

    // millisecond enable, restarted whenever saturation drops
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            divCount <= '0;
            msTick <= 1'b0;
        end else if (!saturated || divCount == 32'(MS_CYCLES_P - 1)) begin
            divCount <= '0;
            msTick <= saturated;
        end else begin
            divCount <= divCount + 32'h1;
            msTick <= 1'b0;
        end
    end

    // count whole milliseconds of unbroken saturation
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            msCount <= '0;
            timeout <= 1'b0;
        end else if (!saturated) begin
            msCount <= '0;
            timeout <= 1'b0;
        end else if (msTick && msCount < msLimit) begin
            msCount <= msCount + 8'h1;
        end else if (msCount >= msLimit) begin
            timeout <= 1'b1;
        end
    end
endmodule

// ==== logic/fsid_regs.sv ====
// fault status, identity and function set register bank
//
// Function
// - read-write bit selects 20 ms or 40 ms ground-short detect; resets 0
// - bit 5 flags an LED channel shorted to ground
// - bit 4 flags an over-temperature fault
// - bit 3 flags an output under-voltage fault
// - bit 2 flags an over-current fault
// - bit 1 flags a shorted LED current source
// - bit 0 flags an open LED current source
// - a set flag stays 1 until read or power reset
// - fault stays latched off until its flag is read with the fault gone, then clears
// - read-only identity byte at offset 0x03 returns a fixed code
// - rate select 00/01/10/11 gives 200k, 400k, 1M, 2.2M Hz
// - host uses bus address 0x38, direction bit, then register offset
`timescale 1ns/1ns
module fsid_regs #(
    parameter int MS_CYCLES_P = fsid_pkg::MS_CYCLES,
    parameter logic [7:0] PART_CODE = 8'h5a // arbitrary identity value
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [6:0] busDevAddr,
    input wire logic [7:0] regAddr,
    input wire logic wrStrobe,
    input wire logic [7:0] wrData,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    output logic rdValid,
    input wire logic compSaturatedPin,
    input wire logic overtempPin,
    input wire logic underVoltPin,
    input wire logic overCurrentPin,
    input wire logic sourceShortPin,
    input wire logic sourceOpenPin,
    output logic [fsid_pkg::NUM_FAULTS-1:0] faultLatchOff,
    output logic [7:0] functionSet1,
    output logic [7:0] functionSet2,
    output logic allShortEnable,
    output logic groundShortDetectTimeSelect,
    output logic [11:0] switchRateKhz
);
    import fsid_pkg::*;

    localparam int NUM_PINS = 6;

    logic addrMatch;
    logic wrHit;
    logic rdHit;
    logic faultRead;
    logic [NUM_PINS-1:0] rawPins;
    logic [NUM_PINS-1:0] syncMeta;
    logic [NUM_PINS-1:0] syncPins;
    logic groundShortTimeout;
    logic [NUM_FAULTS-1:0] faultEvents;
    logic [NUM_FAULTS-1:0] faultFlags;
    logic [7:0] faultRegValue;
    logic [7:0] next_rdData;
    logic [1:0] rateSel;

    // strobes only count when the slave engine was addressed as this part
    assign addrMatch = (busDevAddr == DEV_I2C_ADDR);
    assign wrHit = wrStrobe && addrMatch;
    assign rdHit = rdStrobe && addrMatch;
    assign faultRead = rdHit && (regAddr == ADDR_FAULT);

    // analog protection pins, gathered for the synchroniser
    assign rawPins = {sourceOpenPin, sourceShortPin, overCurrentPin,
                      underVoltPin, overtempPin, compSaturatedPin};

    // two-stage synchronisers; the first stage feeds only the second
    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    syncMeta[i] <= 1'b0;
                    syncPins[i] <= 1'b0;
                end else begin
                    syncMeta[i] <= rawPins[i];
                    syncPins[i] <= syncMeta[i];
                end
            end
        end
    endgenerate

    // ground short only counts after the loop saturates for the window
    fsid_sat_timer #(
        .MS_CYCLES_P(MS_CYCLES_P)
    ) u_sat_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .saturated(syncPins[0]),
        .longSelect(groundShortDetectTimeSelect),
        .timeout(groundShortTimeout)
    );

    // fault events placed at their register bit positions
    assign faultEvents[BIT_GROUND_SHORT] = groundShortTimeout;
    assign faultEvents[BIT_OVERTEMP] = syncPins[1];
    assign faultEvents[BIT_UNDERVOLT] = syncPins[2];
    assign faultEvents[BIT_OVERCURRENT] = syncPins[3];
    assign faultEvents[BIT_SOURCE_SHORT] = syncPins[4];
    assign faultEvents[BIT_SOURCE_OPEN] = syncPins[5];

    // one sticky cell per fault; a read of the fault register clears every flag whose fault is not active
    generate
        for (genvar f = 0; f < NUM_FAULTS; f++) begin : g_fault
            fsid_fault_cell u_cell (
                .clk_sys(clk_sys),
                .reset(reset),
                .faultEvent(faultEvents[f]),
                .readClear(faultRead),
                .flag(faultFlags[f])
            );
        end
    endgenerate

    // the protection logic holds each fault off while its flag stands
    assign faultLatchOff = faultFlags;

    // control bits sharing the fault register with the flags
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            allShortEnable <= 1'b0;
            groundShortDetectTimeSelect <= 1'b0;
        end else if (wrHit && regAddr == ADDR_FAULT) begin
            allShortEnable <= wrData[BIT_ALL_SHORT_EN];
            groundShortDetectTimeSelect <= wrData[BIT_TIME_SELECT];
        end
    end

    // function set registers: plain storage driving the converter
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            functionSet1 <= FUNC1_RESET;
            functionSet2 <= FUNC2_RESET;
        end else if (wrHit && regAddr == ADDR_FUNC1) begin
            functionSet1 <= wrData;
        end else if (wrHit && regAddr == ADDR_FUNC2) begin
            functionSet2 <= wrData;
        end
    end

    // registered so the rate figure never glitches while the field moves
    assign rateSel = functionSet2[RATE_SEL_MSB:RATE_SEL_LSB];
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            switchRateKhz <= fsid_rate_khz(
                FUNC2_RESET[RATE_SEL_MSB:RATE_SEL_LSB]);
        end else begin
            switchRateKhz <= fsid_rate_khz(rateSel);
        end
    end

    // fault register image: two control bits over six flags
    assign faultRegValue = {allShortEnable, groundShortDetectTimeSelect,
                            faultFlags};

    // read multiplexer; unmapped offsets read as zero
    always_comb begin
        next_rdData = READ_ZERO;
        case (regAddr)
            ADDR_FUNC1: next_rdData = functionSet1;
            ADDR_FUNC2: next_rdData = functionSet2;
            ADDR_FAULT: next_rdData = faultRegValue;
            ADDR_IDENT: next_rdData = PART_CODE;
            default: next_rdData = READ_ZERO;
        endcase
    end

    // the byte is captured on the same edge that clears the flags, so the
    // host always sees the value from before the clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdData <= READ_ZERO;
            rdValid <= 1'b0;
        end else if (rdHit) begin
            rdData <= next_rdData;
            rdValid <= 1'b1;
        end else begin
            rdValid <= 1'b0;
        end
    end

    // identity byte comes back unchanged on every read
    a_ident_read: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rdHit && regAddr == ADDR_IDENT) |=> (rdValid && rdData == PART_CODE)
    ) else $error("identity read returned wrong value");

    // the host sees the flags as they stood before the clear
    a_fault_capture: assert property (
        @(posedge clk_sys) disable iff (reset)
        faultRead |=> (rdData[NUM_FAULTS-1:0] == $past(faultFlags))
    ) else $error("fault read did not return latched flags");

    // a read clears every flag whose fault is not active right then
    a_read_clears: assert property (
        @(posedge clk_sys) disable iff (reset)
        faultRead |=> ((faultFlags & ~$past(faultEvents)) == '0)
    ) else $error("fault flag survived read without event");

    // a fault event always leaves its flag set, even during a read
    a_set_wins: assert property (
        @(posedge clk_sys) disable iff (reset)
        (faultEvents != '0) |=>
            ((faultFlags & $past(faultEvents)) == $past(faultEvents))
    ) else $error("fault event lost");

    // without a read no flag may fall
    a_flag_sticky: assert property (
        @(posedge clk_sys) disable iff (reset)
        !faultRead |=> ((faultFlags & $past(faultFlags)) == $past(faultFlags))
    ) else $error("fault flag dropped without read");

    // strobes meant for another bus address are ignored
    a_addr_ignore: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rdStrobe && !addrMatch) |=> !rdValid
    ) else $error("read answered for foreign bus address");

    // writing the fault register sets the detect window select
    a_tsel_write: assert property (
        @(posedge clk_sys) disable iff (reset)
        (wrHit && regAddr == ADDR_FAULT) |=>
            (groundShortDetectTimeSelect == $past(wrData[BIT_TIME_SELECT]))
    ) else $error("time select not written");

    // rate output follows the select field one cycle later
    a_rate_decode: assert property (
        @(posedge clk_sys) disable iff (reset)
        ##1 (switchRateKhz == fsid_rate_khz($past(rateSel)))
    ) else $error("switching rate decode wrong");

    // protection pins reach their flag through two synchroniser stages
    a_pin_to_flag: assert property (
        @(posedge clk_sys) disable iff (reset)
        (overtempPin ##1 overtempPin ##1 overtempPin) |=>
            faultFlags[BIT_OVERTEMP]
    ) else $error("over-temperature pin did not set flag");

    // the four other pin faults follow the same path
    a_pins_other: assert property (
        @(posedge clk_sys) disable iff (reset)
        (syncPins[5:2] != '0) |=>
            (faultFlags[BIT_UNDERVOLT:BIT_SOURCE_OPEN] != '0)
    ) else $error("pin fault did not set a flag");

    // a ground short flag needs the saturation timer to have expired
    a_ground_short: assert property (
        @(posedge clk_sys) disable iff (reset)
        $rose(faultFlags[BIT_GROUND_SHORT]) |-> $past(groundShortTimeout)
    ) else $error("ground short flag set without timeout");

    // a read hit answers with a valid pulse in the next cycle
    a_rdvalid_pulse: assert property (
        @(posedge clk_sys) disable iff (reset)
        rdHit |=> rdValid
    ) else $error("read hit gave no valid pulse");

    // the valid pulse never outlasts its cycle or appears unasked
    a_rdvalid_idle: assert property (
        @(posedge clk_sys) disable iff (reset)
        !rdHit |=> !rdValid
    ) else $error("valid pulse without read hit");

    // the returned byte holds until the next read hit
    a_rdata_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        !rdHit |=> $stable(rdData)
    ) else $error("read data changed without read hit");

    // the detect window select moves only on a fault register write
    a_tsel_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        !(wrHit && regAddr == ADDR_FAULT) |=>
            $stable(groundShortDetectTimeSelect)
    ) else $error("time select changed without write");

    // each rate code checked against its constant, not the decoder
    a_rate_sel0: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rateSel == 2'h0) |=> (switchRateKhz == RATE_SEL0_KHZ)
    ) else $error("rate code 0 decoded wrong");

    a_rate_sel1: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rateSel == 2'h1) |=> (switchRateKhz == RATE_SEL1_KHZ)
    ) else $error("rate code 1 decoded wrong");

    a_rate_sel2: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rateSel == 2'h2) |=> (switchRateKhz == RATE_SEL2_KHZ)
    ) else $error("rate code 2 decoded wrong");

    a_rate_sel3: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rateSel == 2'h3) |=> (switchRateKhz == RATE_SEL3_KHZ)
    ) else $error("rate code 3 decoded wrong");

    // a flag can only rise when its own fault event was present
    a_flag_needs_event: assert property (
        @(posedge clk_sys) disable iff (reset)
        ##1 ((faultFlags & ~$past(faultFlags) & ~$past(faultEvents)) == '0)
    ) else $error("fault flag set without event");
endmodule

// ==== test/fsid_host_model.sv ====
// host side model issuing register strobes as the serial slave engine does
`timescale 1ns/1ns
module fsid_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    output logic [6:0] busDevAddr,
    output logic [7:0] regAddr,
    output logic wrStrobe,
    output logic [7:0] wrData,
    output logic rdStrobe
);
    import fsid_pkg::*;

    // idle bus: strobes low, offset and data lines carry junk, not old values
    initial begin
        busDevAddr = DEV_I2C_ADDR;
        regAddr = 8'h5c;
        wrData = 8'ha3;
        wrStrobe = 1'h0;
        rdStrobe = 1'h0;
    end

    // one-cycle write pulse, launched and released on falling edges
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                             input logic [7:0] data);
        @(negedge clk_sys);
        busDevAddr = dev;
        regAddr = addr;
        wrData = data;
        wrStrobe = 1'h1;
        @(negedge clk_sys);
        wrStrobe = 1'h0;
        regAddr = ~addr;
        wrData = ~data;
    endtask

    // one-cycle read pulse; the answer is taken in the following cycle
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] addr,
                            output logic [7:0] data, output logic valid);
        @(negedge clk_sys);
        busDevAddr = dev;
        regAddr = addr;
        rdStrobe = 1'h1;
        @(negedge clk_sys);
        rdStrobe = 1'h0;
        regAddr = ~addr;
        valid = rdValid;
        data = rdData;
    endtask
endmodule

// ==== test/fsid_regs_tb.sv ====
// self-checking bench for the fault status and identity bank
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin testsRun++; if ((g) !== (e)) begin failCount++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module fsid_regs_tb;
    import fsid_pkg::*;
    localparam int MSC = 10;
    localparam logic [7:0] CODE = 8'h3c; // arbitrary identity value
    localparam logic [6:0] DEV = 7'h38;
    typedef struct packed {
        logic [6:0] dev;
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic expValid;
        logic [7:0] expData;
    } fsid_row_t;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic [6:0] busDevAddr;
    logic [7:0] regAddr, wrData, rdData, functionSet1, functionSet2, rdGot;
    logic wrStrobe, rdStrobe, rdValid, allShortEnable, vGot;
    logic groundShortDetectTimeSelect;
    logic compSaturatedPin = 1'h0;
    logic [4:0] faultPins = 5'h0;
    logic [5:0] faultLatchOff;
    logic [11:0] switchRateKhz;
    int failCount = 0;
    int testsRun = 0;
    int cycles = 0;
    logic [11:0] rates [4] = '{12'h0c8, 12'h190, 12'h3e8, 12'h898};
    // wrong device address rows must be ignored entirely
    fsid_row_t rows [14] = '{
        '{DEV, 1'h0, 8'h00, 8'h00, 1'h1, 8'h86},
        '{DEV, 1'h0, 8'h01, 8'h00, 1'h1, 8'h28},
        '{DEV, 1'h0, 8'h02, 8'h00, 1'h1, 8'h00},
        '{DEV, 1'h0, 8'h03, 8'h00, 1'h1, CODE},
        '{DEV, 1'h0, 8'h07, 8'h00, 1'h1, 8'h00},
        '{7'h39, 1'h0, 8'h00, 8'h00, 1'h0, 8'h00},
        '{7'h39, 1'h1, 8'h02, 8'hc0, 1'h0, 8'h00},
        '{DEV, 1'h0, 8'h02, 8'h00, 1'h1, 8'h00},
        '{DEV, 1'h1, 8'h02, 8'hff, 1'h0, 8'h00},
        '{DEV, 1'h0, 8'h02, 8'h00, 1'h1, 8'hc0},
        '{DEV, 1'h1, 8'h03, 8'hff, 1'h0, 8'h00},
        '{DEV, 1'h0, 8'h03, 8'h00, 1'h1, CODE},
        '{DEV, 1'h1, 8'h02, 8'h40, 1'h0, 8'h00},
        '{DEV, 1'h0, 8'h02, 8'h00, 1'h1, 8'h40}};

    fsid_regs #(.MS_CYCLES_P(MSC), .PART_CODE(CODE)) fsid_regs_i (
        .clk_sys(clk_sys), .reset(reset), .busDevAddr(busDevAddr),
        .regAddr(regAddr), .wrStrobe(wrStrobe), .wrData(wrData),
        .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid),
        .compSaturatedPin(compSaturatedPin), .overtempPin(faultPins[4]),
        .underVoltPin(faultPins[3]), .overCurrentPin(faultPins[2]),
        .sourceShortPin(faultPins[1]), .sourceOpenPin(faultPins[0]),
        .faultLatchOff(faultLatchOff), .functionSet1(functionSet1),
        .functionSet2(functionSet2), .allShortEnable(allShortEnable),
        .groundShortDetectTimeSelect(groundShortDetectTimeSelect),
        .switchRateKhz(switchRateKhz));

    fsid_host_model fsid_host_model_i (
        .clk_sys(clk_sys), .rdData(rdData), .rdValid(rdValid),
        .busDevAddr(busDevAddr), .regAddr(regAddr), .wrStrobe(wrStrobe),
        .wrData(wrData), .rdStrobe(rdStrobe));

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    // verdict and end of run, shared by the main sequence and the timeout
    task automatic complete_run();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, well above the longest saturation window
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            complete_run();
        end
    end

    // saturation held past the selected window sets the ground short flag
    task automatic gs_check(input logic sel, input int ms);
        fsid_host_model_i.write_reg(DEV, 8'h02, {1'h0, sel, 6'h0});
        compSaturatedPin = 1'h1;
        repeat (ms * MSC - 5) @(negedge clk_sys);
        `CHK("early short", 1'h0, faultLatchOff[5])
        repeat (15) @(negedge clk_sys);
        `CHK("short flag", 1'h1, faultLatchOff[5])
        compSaturatedPin = 1'h0;
        // let the timeout fall first, else the set beats the read clear
        repeat (4) @(negedge clk_sys);
        fsid_host_model_i.read_reg(DEV, 8'h02, rdGot, vGot);
        `CHK("short byte", {1'h0, sel, 6'h20}, rdGot)
        `CHK("short clear", 1'h0, faultLatchOff[5])
    endtask

    initial begin
        repeat (8) @(negedge clk_sys);
        reset = 1'h0;
        // table of plain register accesses
        for (int i = 0; i < 14; i++) begin
            if (rows[i].wr) begin
                fsid_host_model_i.write_reg(rows[i].dev, rows[i].addr,
                                            rows[i].data);
            end else begin
                fsid_host_model_i.read_reg(rows[i].dev, rows[i].addr,
                                           rdGot, vGot);
                `CHK("rdValid", rows[i].expValid, vGot)
                if (rows[i].expValid) begin
                    `CHK("rdData", rows[i].expData, rdGot)
                end
            end
        end
        `CHK("time select", 1'h1, groundShortDetectTimeSelect)
        `CHK("short enable", 1'h0, allShortEnable)
        // function set 1 only takes writes addressed to this part
        fsid_host_model_i.write_reg(7'h39, 8'h00, 8'h11);
        `CHK("func1 foreign", 8'h86, functionSet1)
        fsid_host_model_i.write_reg(DEV, 8'h00, 8'h11);
        `CHK("func1 write", 8'h11, functionSet1)
        // every rate code decodes to its frequency
        for (int i = 0; i < 4; i++) begin
            fsid_host_model_i.write_reg(DEV, 8'h01, {3'h0, 2'(i), 3'h0});
            repeat (2) @(negedge clk_sys);
            `CHK("rate", rates[i], switchRateKhz)
        end
        `CHK("rate field", 8'h18, functionSet2)
        // each fault pulse sticks, reads back in place, then clears
        for (int b = 0; b < 5; b++) begin
            faultPins = 5'h01 << b;
            repeat (5) @(negedge clk_sys);
            faultPins = 5'h0;
            repeat (3) @(negedge clk_sys);
            `CHK("sticky", 6'h01 << b, faultLatchOff)
            fsid_host_model_i.read_reg(DEV, 8'h02, rdGot, vGot);
            `CHK("fault byte", 8'h40 | (8'h01 << b), rdGot)
            `CHK("bits", 6'h01 << b, rdGot[5:0])
            `CHK("cleared", 6'h0, faultLatchOff)
        end
        // fault still present while read: flag survives the clear
        faultPins = 5'h04;
        repeat (5) @(negedge clk_sys);
        fsid_host_model_i.read_reg(DEV, 8'h02, rdGot, vGot);
        `CHK("busy read", 8'h44, rdGot)
        `CHK("kept", 6'h04, faultLatchOff)
        faultPins = 5'h0;
        repeat (3) @(negedge clk_sys);
        fsid_host_model_i.read_reg(DEV, 8'h02, rdGot, vGot);
        `CHK("late read", 8'h44, rdGot)
        `CHK("late clear", 6'h0, faultLatchOff)
        gs_check(1'h0, 20);
        gs_check(1'h1, 40);
        // reset in mid-run wipes a set flag and the time select
        faultPins = 5'h01;
        repeat (5) @(negedge clk_sys);
        fsid_host_model_i.write_reg(DEV, 8'h02, 8'hc0);
        reset = 1'h1;
        faultPins = 5'h0;
        @(negedge clk_sys);
        `CHK("reset flags", 6'h0, faultLatchOff)
        `CHK("reset tsel", 1'h0, groundShortDetectTimeSelect)
        `CHK("reset rate", 12'h190, switchRateKhz)
        repeat (3) @(negedge clk_sys);
        reset = 1'h0;
        fsid_host_model_i.read_reg(DEV, 8'h02, rdGot, vGot);
        `CHK("reset byte", 8'h00, rdGot)
        complete_run();
    end
endmodule
